// file: hw/ps_table_pkg.sv
// Constants shared by the program-space table access block.
// Assumes a 16-bit register port and 24-bit program words.
package ps_table_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_PAGE     = 8'h00;
  localparam logic [7:0] REG_CTRL     = 8'h04;
  localparam logic [7:0] REG_ADDR_LO  = 8'h08;
  localparam logic [7:0] REG_ADDR_HI  = 8'h0c;
  localparam logic [7:0] REG_KEY      = 8'h10;

  // ----------------------------------------------------------------
  // Control register fields and reset values
  // ----------------------------------------------------------------
  localparam int         CTRL_START   = 15;
  localparam int         CTRL_ENABLE  = 14;
  localparam int         CTRL_ERROR   = 13;
  localparam int         PAGE_CFG_BIT = 7;
  localparam logic [7:0] PAGE_RST     = 8'h00;
  localparam logic [3:0] OP_RST       = 4'h0;

  localparam logic [3:0] OP_DWORD     = 4'h1;
  localparam logic [3:0] OP_ROW       = 4'h2;
  localparam logic [3:0] OP_ERASE     = 4'h3;

  localparam logic [15:0] KEY_FIRST   = 16'h0055;
  localparam logic [15:0] KEY_SECOND  = 16'h00aa;

  // ----------------------------------------------------------------
  // Array geometry
  // ----------------------------------------------------------------
  localparam int BYTES_PER_WORD = 3;
  localparam int ROW_BYTES      = 192;
  localparam int PAGE_BYTES     = 1536;
  localparam int ROW_WORDS      = ROW_BYTES / BYTES_PER_WORD;
  localparam int PAGE_WORDS     = PAGE_BYTES / BYTES_PER_WORD;
  localparam int DWORD_WORDS    = 2;
  localparam logic [23:0] ERASED_WORD = 24'hffffff;

  // ----------------------------------------------------------------
  // Operation sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SEQ_IDLE   = 2'b00,
    SEQ_RUN    = 2'b01,
    SEQ_FINISH = 2'b11
  } seq_state_t;

endpackage : ps_table_pkg

// file: hw/prog_word_mem.sv
// Small 24-bit word memory with byte-lane writes and registered read.
// Assumes one writer and one reader on the same clock.
`timescale 1ns/1ps
`default_nettype none
module prog_word_mem #(
  parameter int DEPTH = 64,
  parameter int AW    = 6
) (
  // Clock and reset
  input  wire logic          core_clk,
  input  wire logic          reset,
  // Write port
  input  wire logic          wr_en,
  input  wire logic [2:0]    wr_lane,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [23:0]   wr_data,
  // Read port
  input  wire logic          rd_en,
  input  wire logic [AW-1:0] rd_addr,
  output logic      [23:0]   rd_data
);

  logic [23:0] mem [DEPTH];

  always_ff @(posedge core_clk)
  begin
    if (wr_en)
    begin
      for (int i = 0; i < 3; i++)
      begin
        if (wr_lane[i])
        begin
          mem[wr_addr][i*8 +: 8] <= wr_data[i*8 +: 8];
        end
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      rd_data <= 24'h000000;
    end
    else if (rd_en)
    begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule : prog_word_mem
`default_nettype wire

// file: hw/read_lane_mapper.sv
// Maps a 24-bit program word onto 16-bit read data.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ps
`default_nettype none
module read_lane_mapper (
  // Program word and access shape
  input  wire logic [23:0] word,
  input  wire logic        high_op,
  input  wire logic        byte_mode,
  input  wire logic        byte_sel,
  // Mapped data
  output logic      [15:0] data
);

  always_comb
  begin
    if (!high_op)
    begin
      if (byte_mode)
      begin
        data = {8'h00, (byte_sel ? word[15:8] : word[7:0])}; // see R6
      end
      else
      begin
        data = word[15:0]; // see R5
      end
    end
    else if (byte_mode && byte_sel)
    begin
      data = 16'h0000; // see R8
    end
    else
    begin
      data = {8'h00, word[23:16]}; // see R7 R8
    end
  end

endmodule : read_lane_mapper
`default_nettype wire

// file: hw/program_space_table_access.sv
// Table access to 24-bit program memory, remap read port, fetch port
// and the self-timed row/page sequencer. Assumes the core keeps its
// request stable only for the cycle it is taken.
//
// Operation
// R1: Target address is the page register above the 16-bit effective address.
// R2: Page top bit 0 selects user memory, 1 selects configuration memory.
// R3: Fetch and remap addresses have bit 0 forced to zero.
// R4: Unaligned table accesses and configuration-space reads are accepted.
// R5: Low word read, word mode, returns program bits 15..0.
// R6: Low byte read returns upper byte when select is 1, lower when 0.
// R7: High word read returns bits 23..16 with upper data byte zero.
// R8: High byte read returns upper byte, or zero for the phantom byte.
// R9: Program counter advances by two per 24-bit word.
// R10: Low ops reach the low word, high ops the upper byte, same range.
// R11: Low and high reads and writes support word and byte modes.
// R12: Remap window is read-only and returns only the low word.
// R13: Rows are 64 words; row program writes exactly one row.
// R14: Page erase clears 512 words; program does one row or two words.
// R15: Pages align on 1536 bytes, rows on 192 bytes, from address zero.
// R16: Start flag begins the operation and hardware clears it when done.
// R17: Software writes 0x55 then 0xaa to the key before any start.
//
// The implementer's own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module program_space_table_access #(
  parameter int FLASH_WORDS = 4096,
  parameter int FLASH_AW    = 12,
  parameter int CFG_WORDS   = 16,
  parameter int CFG_AW      = 4
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  // Table instruction port
  input  wire logic        tbl_req,
  input  wire logic        tbl_write,
  input  wire logic        tbl_high,
  input  wire logic        tbl_byte,
  input  wire logic [15:0] effective_address,
  input  wire logic [15:0] tbl_wdata,
  output logic             tbl_ready,
  output logic      [15:0] tbl_rdata,
  output logic             tbl_rvalid,
  // Remap window, read only
  input  wire logic        remap_req,
  input  wire logic [23:0] remap_addr,
  output logic             remap_ready,
  output logic      [15:0] remap_rdata,
  output logic             remap_rvalid,
  // Instruction fetch
  input  wire logic        fetch_load,
  input  wire logic [23:0] fetch_pc,
  input  wire logic        fetch_req,
  output logic             fetch_ready,
  output logic      [23:0] fetch_word,
  output logic             fetch_valid,
  // Status
  output logic             nvm_busy
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0]              page;
    logic                    start;
    logic                    wen;
    logic                    err;
    logic [3:0]              op;
    logic [23:0]             nvm_addr;
    logic                    key_stage;
    logic                    armed;
    ps_table_pkg::seq_state_t st;
    logic [9:0]              cnt;
    logic [9:0]              last;
    logic                    wr_pend;
    logic [9:0]              wr_idx;
    logic [15:0]             bus_rdata;
    logic                    t_p1;
    logic                    t_high;
    logic                    t_byte;
    logic                    t_bsel;
    logic                    t_cfg;
    logic                    p_p1;
    logic                    f_p1;
    logic [15:0]             t_rdata;
    logic                    t_rvalid;
    logic [15:0]             p_rdata;
    logic                    p_rvalid;
    logic [23:0]             f_word;
    logic                    f_valid;
    logic [23:0]             pc;
  } state_t;

  state_t s_ff;
  state_t nxt_s;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [2:0] write_lanes(input logic hi, input logic by,
                                             input logic bs);
    if (!hi)
    begin
      write_lanes = by ? (bs ? 3'b010 : 3'b001) : 3'b011;
    end
    else
    begin
      write_lanes = (by && bs) ? 3'b000 : 3'b100;
    end
  endfunction : write_lanes

  function automatic logic [23:0] write_word(input logic hi, input logic by,
                                             input logic [15:0] d);
    if (hi)
    begin
      write_word = {d[7:0], 16'h0000};
    end
    else
    begin
      write_word = by ? {8'h00, d[7:0], d[7:0]} : {8'h00, d};
    end
  endfunction : write_word

  // ----------------------------------------------------------------
  // Memories and read mapping
  // ----------------------------------------------------------------
  logic [23:0]         flash_rd;
  logic [23:0]         cfg_rd;
  logic [23:0]         latch_rd;
  logic [23:0]         tbl_addr;
  logic                tbl_take;
  logic                tbl_cfg;
  logic                remap_take;
  logic                fetch_take;
  logic                flash_rd_en;
  logic [FLASH_AW-1:0] flash_rd_addr;
  logic [FLASH_AW-1:0] op_base;
  logic [FLASH_AW-1:0] flash_wr_addr;
  logic [5:0]          latch_idx;
  logic [2:0]          lanes;
  logic [23:0]         lane_data;
  logic [15:0]         mapped;

  assign tbl_addr   = {s_ff.page, effective_address}; // see R1
  assign tbl_cfg    = s_ff.page[ps_table_pkg::PAGE_CFG_BIT]; // see R2
  assign tbl_ready  = (s_ff.st == ps_table_pkg::SEQ_IDLE);
  assign tbl_take   = tbl_req && tbl_ready; // see R4
  assign remap_ready = tbl_ready && !tbl_req;
  assign remap_take  = remap_req && remap_ready;
  assign fetch_ready = remap_ready && !remap_req;
  assign fetch_take  = fetch_req && fetch_ready && !fetch_load;
  assign nvm_busy    = s_ff.start;
  assign lanes       = write_lanes(tbl_high, tbl_byte, effective_address[0]); // see R11
  assign lane_data   = write_word(tbl_high, tbl_byte, tbl_wdata); // see R10
  assign op_base     = s_ff.nvm_addr[FLASH_AW:1] & ~FLASH_AW'(s_ff.last); // see R15
  assign flash_wr_addr = op_base + FLASH_AW'(s_ff.wr_idx);
  assign latch_idx   = op_base[5:0] + s_ff.cnt[5:0];

  always_comb
  begin
    flash_rd_en   = 1'b1;
    flash_rd_addr = tbl_addr[FLASH_AW:1];
    if (remap_take)
    begin
      flash_rd_addr = remap_addr[FLASH_AW:1]; // see R3 R12
    end
    else if (!tbl_take)
    begin
      flash_rd_addr = s_ff.pc[FLASH_AW:1]; // see R3
      flash_rd_en   = fetch_take;
    end
  end

  prog_word_mem #(.DEPTH(FLASH_WORDS), .AW(FLASH_AW)) u_flash (
    .core_clk (core_clk),
    .reset    (reset),
    .wr_en    (s_ff.wr_pend),
    .wr_lane  (3'b111),
    .wr_addr  (flash_wr_addr),
    .wr_data  ((s_ff.op == ps_table_pkg::OP_ERASE) ? ps_table_pkg::ERASED_WORD : latch_rd),
    .rd_en    (flash_rd_en),
    .rd_addr  (flash_rd_addr),
    .rd_data  (flash_rd)
  );

  // User-space writes land in the row latch; the array only changes by a program or erase
  prog_word_mem #(.DEPTH(ps_table_pkg::ROW_WORDS), .AW(6)) u_latch (
    .core_clk (core_clk),
    .reset    (reset),
    .wr_en    (tbl_take && tbl_write && !tbl_cfg),
    .wr_lane  (lanes),
    .wr_addr  (tbl_addr[6:1]),
    .wr_data  (lane_data),
    .rd_en    (s_ff.st == ps_table_pkg::SEQ_RUN),
    .rd_addr  (latch_idx),
    .rd_data  (latch_rd)
  );

  prog_word_mem #(.DEPTH(CFG_WORDS), .AW(CFG_AW)) u_cfg (
    .core_clk (core_clk),
    .reset    (reset),
    .wr_en    (tbl_take && tbl_write && tbl_cfg),
    .wr_lane  (lanes),
    .wr_addr  (tbl_addr[CFG_AW:1]),
    .wr_data  (lane_data),
    .rd_en    (tbl_take && tbl_cfg),
    .rd_addr  (tbl_addr[CFG_AW:1]),
    .rd_data  (cfg_rd)
  );

  read_lane_mapper u_map (
    .word      (s_ff.t_cfg ? cfg_rd : flash_rd),
    .high_op   (s_ff.t_high),
    .byte_mode (s_ff.t_byte),
    .byte_sel  (s_ff.t_bsel),
    .data      (mapped)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_s = s_ff;
    nxt_s.t_p1     = tbl_take && !tbl_write;
    nxt_s.p_p1     = remap_take;
    nxt_s.f_p1     = fetch_take;
    nxt_s.t_rvalid = s_ff.t_p1;
    nxt_s.p_rvalid = s_ff.p_p1;
    nxt_s.f_valid  = s_ff.f_p1;
    nxt_s.wr_pend  = 1'b0;
    if (tbl_take)
    begin
      nxt_s.t_high = tbl_high;
      nxt_s.t_byte = tbl_byte;
      nxt_s.t_bsel = effective_address[0];
      nxt_s.t_cfg  = tbl_cfg;
    end
    if (s_ff.t_p1)
    begin
      nxt_s.t_rdata = mapped;
    end
    if (s_ff.p_p1)
    begin
      nxt_s.p_rdata = flash_rd[15:0]; // see R12
    end
    if (s_ff.f_p1)
    begin
      nxt_s.f_word = flash_rd;
    end
    if (fetch_load)
    begin
      nxt_s.pc = {fetch_pc[23:1], 1'b0}; // see R3
    end
    else if (fetch_take)
    begin
      nxt_s.pc = s_ff.pc + 24'h000002; // see R9
    end

    // Register reads
    nxt_s.bus_rdata = 16'h0000;
    if (reg_rd)
    begin
      case (reg_addr)
        ps_table_pkg::REG_PAGE:    nxt_s.bus_rdata = {8'h00, s_ff.page};
        ps_table_pkg::REG_CTRL:
          nxt_s.bus_rdata = {s_ff.start, s_ff.wen, s_ff.err, 9'h000, s_ff.op};
        ps_table_pkg::REG_ADDR_LO: nxt_s.bus_rdata = s_ff.nvm_addr[15:0];
        ps_table_pkg::REG_ADDR_HI: nxt_s.bus_rdata = {8'h00, s_ff.nvm_addr[23:16]};
        default:                   nxt_s.bus_rdata = 16'h0000;
      endcase
    end

    // Register writes; the key arms only the very next write
    if (reg_wr)
    begin
      nxt_s.key_stage = 1'b0;
      nxt_s.armed     = 1'b0;
      case (reg_addr)
        ps_table_pkg::REG_PAGE: nxt_s.page = reg_wdata[7:0];
        ps_table_pkg::REG_ADDR_LO:
        begin
          if (!s_ff.start)
          begin
            nxt_s.nvm_addr[15:0] = reg_wdata;
          end
        end
        ps_table_pkg::REG_ADDR_HI:
        begin
          if (!s_ff.start)
          begin
            nxt_s.nvm_addr[23:16] = reg_wdata[7:0];
          end
        end
        ps_table_pkg::REG_KEY:
        begin
          nxt_s.key_stage = (reg_wdata == ps_table_pkg::KEY_FIRST);
          nxt_s.armed = s_ff.key_stage && (reg_wdata == ps_table_pkg::KEY_SECOND); // see R17
        end
        ps_table_pkg::REG_CTRL:
        begin
          if (!reg_wdata[ps_table_pkg::CTRL_ERROR])
          begin
            nxt_s.err = 1'b0;
          end
          if (!s_ff.start)
          begin
            nxt_s.wen = reg_wdata[ps_table_pkg::CTRL_ENABLE];
            nxt_s.op  = reg_wdata[3:0];
            if (reg_wdata[ps_table_pkg::CTRL_START])
            begin
              if (s_ff.armed && reg_wdata[ps_table_pkg::CTRL_ENABLE]
                  && (reg_wdata[3:0] == ps_table_pkg::OP_DWORD
                  || reg_wdata[3:0] == ps_table_pkg::OP_ROW
                  || reg_wdata[3:0] == ps_table_pkg::OP_ERASE))
              begin
                nxt_s.start = 1'b1; // see R16
                nxt_s.st    = ps_table_pkg::SEQ_RUN;
                nxt_s.cnt   = 10'd0;
                case (reg_wdata[3:0])
                  ps_table_pkg::OP_ROW:   nxt_s.last = 10'(ps_table_pkg::ROW_WORDS - 1); // see R13
                  ps_table_pkg::OP_ERASE: nxt_s.last = 10'(ps_table_pkg::PAGE_WORDS - 1); // see R14
                  default:                nxt_s.last = 10'(ps_table_pkg::DWORD_WORDS - 1); // see R14
                endcase
              end
              else
              begin
                // Error set is applied after the clear so it wins
                nxt_s.err = 1'b1;
              end
            end
          end
        end
        default:
        begin
        end
      endcase
    end

    // Sequencer: one word per cycle, write trails latch read by one
    case (s_ff.st)
      ps_table_pkg::SEQ_IDLE:
      begin
      end
      ps_table_pkg::SEQ_RUN:
      begin
        nxt_s.wr_pend = 1'b1;
        nxt_s.wr_idx  = s_ff.cnt;
        nxt_s.cnt     = s_ff.cnt + 10'd1;
        if (s_ff.cnt == s_ff.last)
        begin
          nxt_s.st = ps_table_pkg::SEQ_FINISH; // see R13 R14
        end
      end
      ps_table_pkg::SEQ_FINISH:
      begin
        nxt_s.start = 1'b0; // see R16
        nxt_s.st    = ps_table_pkg::SEQ_IDLE;
      end
      default:
      begin
        nxt_s.st = ps_table_pkg::SEQ_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      s_ff       <= '0;
      s_ff.page  <= ps_table_pkg::PAGE_RST;
      s_ff.op    <= ps_table_pkg::OP_RST;
      s_ff.st    <= ps_table_pkg::SEQ_IDLE;
    end
    else
    begin
      s_ff <= nxt_s;
    end
  end

  assign reg_rdata    = s_ff.bus_rdata;
  assign tbl_rdata    = s_ff.t_rdata;
  assign tbl_rvalid   = s_ff.t_rvalid;
  assign remap_rdata  = s_ff.p_rdata;
  assign remap_rvalid = s_ff.p_rvalid;
  assign fetch_word   = s_ff.f_word;
  assign fetch_valid  = s_ff.f_valid;

endmodule : program_space_table_access
`default_nettype wire

// file: sim/ps_table_asserts.sv
// Port-level checks for the table access block.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module ps_table_asserts (
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        reset,
  // Table port
  input wire logic        tbl_req,
  input wire logic        tbl_write,
  input wire logic        tbl_high,
  input wire logic        tbl_byte,
  input wire logic [15:0] effective_address,
  input wire logic        tbl_ready,
  input wire logic [15:0] tbl_rdata,
  input wire logic        tbl_rvalid,
  // Remap, fetch, status
  input wire logic        remap_req,
  input wire logic        remap_ready,
  input wire logic        remap_rvalid,
  input wire logic        fetch_load,
  input wire logic        fetch_req,
  input wire logic        fetch_ready,
  input wire logic        fetch_valid,
  input wire logic        nvm_busy
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);
  logic rd_take;
  assign rd_take = tbl_req && tbl_ready && !tbl_write;

  property p_busy_blocks;
    nvm_busy |-> !tbl_ready;
  endproperty
  a_busy_blocks: assert property (p_busy_blocks)
    else $error("table port ready while busy");
  property p_busy_min;
    $rose(nvm_busy) |-> nvm_busy[*3];
  endproperty
  a_busy_min: assert property (p_busy_min)
    else $error("operation shorter than two words");
  property p_busy_max;
    $rose(nvm_busy) |-> ##[1:514] !nvm_busy;
  endproperty
  a_busy_max: assert property (p_busy_max)
    else $error("busy flag not cleared");
  property p_rd_latency;
    rd_take |-> ##2 tbl_rvalid;
  endproperty
  a_rd_latency: assert property (p_rd_latency)
    else $error("table read result late");
  property p_rd_cause;
    tbl_rvalid |-> $past(rd_take, 2);
  endproperty
  a_rd_cause: assert property (p_rd_cause)
    else $error("table result without read");
  property p_phantom;
    tbl_rvalid && $past(rd_take && tbl_high && tbl_byte && effective_address[0], 2)
      |-> tbl_rdata == 16'h0000;
  endproperty
  a_phantom: assert property (p_phantom)
    else $error("phantom byte not zero");
  property p_high_zero;
    tbl_rvalid && $past(rd_take && (tbl_high || tbl_byte), 2) |-> tbl_rdata[15:8] == 8'h00;
  endproperty
  a_high_zero: assert property (p_high_zero)
    else $error("upper data byte not zero");
  property p_remap_latency;
    remap_req && remap_ready |-> ##2 remap_rvalid;
  endproperty
  a_remap_latency: assert property (p_remap_latency)
    else $error("remap result late");
  property p_fetch_latency;
    fetch_req && fetch_ready && !fetch_load |-> ##2 fetch_valid;
  endproperty
  a_fetch_latency: assert property (p_fetch_latency)
    else $error("fetch result late");
endmodule : ps_table_asserts
bind program_space_table_access ps_table_asserts chk_u (.*);
`default_nettype wire

// file: sim/core_table_model.sv
// Core model that issues table reads and writes.
// Assumes the bench hands it one command at a time.
`timescale 1ns/1ps
`default_nettype none
module core_table_model (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset,
  // Command from the bench: kind is write, high, byte
  input  wire logic        cmd_go,
  input  wire logic [1:0]  cmd_delay,
  input  wire logic [2:0]  cmd_kind,
  input  wire logic [15:0] cmd_ea,
  input  wire logic [15:0] cmd_wdata,
  // Table port
  output logic             tbl_req,
  output logic             tbl_write,
  output logic             tbl_high,
  output logic             tbl_byte,
  output logic      [15:0] effective_address,
  output logic      [15:0] tbl_wdata,
  input  wire logic        tbl_ready
);
  logic [1:0] wait_ff;
  logic       pend_ff;
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      tbl_req                         <= 1'b0;
      pend_ff                         <= 1'b0;
      {tbl_write, tbl_high, tbl_byte} <= 3'b000;
      effective_address               <= 16'h0000;
      tbl_wdata                       <= 16'h0000;
    end
    else if (tbl_req && tbl_ready)
    begin
      // Released lines must not keep showing the last value
      tbl_req           <= 1'b0;
      effective_address <= ~effective_address;
      tbl_wdata         <= ~tbl_wdata;
    end
    else if (cmd_go)
    begin
      {tbl_write, tbl_high, tbl_byte} <= cmd_kind;
      effective_address               <= cmd_ea;
      tbl_wdata                       <= cmd_wdata;
      wait_ff                         <= cmd_delay;
      pend_ff                         <= 1'b1;
    end
    else if (pend_ff)
    begin
      wait_ff <= wait_ff - 2'd1;
      pend_ff <= wait_ff != 2'd0;
      tbl_req <= wait_ff == 2'd0;
    end
  end
endmodule : core_table_model
`default_nettype wire

// file: sim/test_program_space_table_access.sv
// Self-checking bench for the table access block.
// Assumes the checker is bound in and the core model drives the table port.
`timescale 1ns/1ps
`default_nettype none
module test_program_space_table_access;
  logic core_clk, reset, reg_wr, reg_rd, cmd_go, remap_req, fetch_load, fetch_req;
  logic tbl_req, tbl_write, tbl_high, tbl_byte, tbl_ready, tbl_rvalid, remap_ready;
  logic remap_rvalid, fetch_ready, fetch_valid, nvm_busy;
  logic [1:0]  cmd_delay;
  logic [2:0]  cmd_kind;
  logic [7:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, cmd_ea, cmd_wdata, effective_address, tbl_wdata, v;
  logic [15:0] tbl_rdata, remap_rdata;
  logic [23:0] remap_addr, fetch_pc, fetch_word;
  logic [23:0] exp_w [8];
  logic [31:0] seed = 32'h88c6ad09;
  logic [31:0] r;
  int          bad_count = 0;
  int          tests_run = 0;
  int          cycles = 0;
  int          k;

  program_space_table_access dut_u (.*);
  core_table_model core_u (.*);

  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  function automatic logic [15:0] lane(logic [23:0] w, logic h, logic b, logic s);
    if (!h)
      return b ? {8'h00, s ? w[15:8] : w[7:0]} : w[15:0];
    return (b && s) ? 16'h0000 : {8'h00, w[23:16]};
  endfunction : lane

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic close_out();
    if (bad_count == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out

  // Writes hold the strobe; the next task lowers it, so no double drive per step
  task automatic reg_write(input logic [7:0] a, input logic [15:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
  endtask : reg_write

  task automatic reg_read(input logic [7:0] a, output logic [15:0] d);
    reg_addr <= a;
    reg_wr   <= 1'b0;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    d = reg_rdata;
    @(posedge core_clk);
  endtask : reg_read

  task automatic tbl_op(input logic [2:0] kind, input logic [15:0] ea, input logic [15:0] wd,
                        output logic [15:0] d);
    int n;
    reg_wr    <= 1'b0;
    cmd_kind  <= kind;
    cmd_ea    <= ea;
    cmd_wdata <= wd;
    cmd_delay <= 2'(rnd());
    cmd_go    <= 1'b1;
    @(posedge core_clk);
    cmd_go <= 1'b0;
    for (n = 0; n < 20 && !(tbl_req === 1'b1 && tbl_ready === 1'b1); n++)
      @(negedge core_clk);
    @(posedge core_clk);
    for (n = 0; n < 4 && !kind[2] && tbl_rvalid !== 1'b1; n++)
      @(negedge core_clk);
    d = tbl_rdata;
    @(posedge core_clk);
  endtask : tbl_op

  task automatic start_op(input logic [15:0] ctrl, input int len);
    int n;
    reg_write(ps_table_pkg::REG_KEY, ps_table_pkg::KEY_FIRST);
    reg_write(ps_table_pkg::REG_KEY, ps_table_pkg::KEY_SECOND);
    reg_write(ps_table_pkg::REG_CTRL, ctrl);
    reg_wr <= 1'b0;
    n = 0;
    @(negedge core_clk);
    while (nvm_busy === 1'b1 && n < 600)
    begin
      n++;
      @(negedge core_clk);
    end
    check(n, len);
    @(posedge core_clk);
  endtask : start_op

  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      bad_count++;
      close_out();
    end
  end

  initial
  begin
    {reset, reg_wr, reg_rd, cmd_go, remap_req, fetch_load, fetch_req} = 7'b1000000;
    {reg_addr, reg_wdata, cmd_delay, cmd_kind, cmd_ea, cmd_wdata} = '0;
    {remap_addr, fetch_pc} = '0;
    repeat (20) @(posedge core_clk);
    reset <= 1'b0;
    reg_read(ps_table_pkg::REG_PAGE, v);
    check(v, ps_table_pkg::PAGE_RST);
    reg_read(8'h14, v);
    check(v, 16'h0000);
    // A start without the key sequence raises the error flag and latches enable and op without starting
    reg_write(ps_table_pkg::REG_CTRL, 16'hc003);
    reg_read(ps_table_pkg::REG_CTRL, v);
    check({nvm_busy, v}, 17'h06003);
    reg_write(ps_table_pkg::REG_ADDR_LO, 16'h0000);
    reg_write(ps_table_pkg::REG_ADDR_HI, 16'h0000);
    start_op(16'hc003, ps_table_pkg::PAGE_WORDS + 1);
    for (k = 0; k < 8; k++)
    begin
      tbl_op({1'b0, k[1:0]}, 16'h000a | 16'(k[2]), 16'h0000, v);
      check(v, lane(ps_table_pkg::ERASED_WORD, k[1], k[0], k[2]));
    end
    for (k = 0; k < 8; k++)
    begin
      r = rnd();
      exp_w[k] = r[23:0];
      tbl_op(3'b100, 16'(2 * k), r[15:0], v);
      tbl_op(3'b110, 16'(2 * k), {8'h00, r[23:16]}, v);
    end
    tbl_op(3'b101, 16'h000f, 16'h005a, v);
    exp_w[7][15:8] = 8'h5a;
    start_op(16'hc002, ps_table_pkg::ROW_WORDS + 1);
    start_op(16'hc001, ps_table_pkg::DWORD_WORDS + 1);
    for (k = 0; k < 32; k++)
    begin
      r = rnd();
      tbl_op({1'b0, r[1:0]}, {12'h000, r[4:2], r[5]}, 16'h0000, v);
      check(v, lane(exp_w[r[4:2]], r[1], r[0], r[5]));
    end
    reg_write(ps_table_pkg::REG_PAGE, 16'h0080);
    tbl_op(3'b100, 16'h0002, 16'h1234, v);
    tbl_op(3'b000, 16'h0002, 16'h0000, v);
    check(v, 16'h1234);
    reg_write(ps_table_pkg::REG_PAGE, 16'h0000);
    tbl_op(3'b000, 16'h0002, 16'h0000, v);
    check(v, exp_w[1][15:0]);
    remap_addr <= 24'h000007;
    remap_req  <= 1'b1;
    @(posedge core_clk);
    remap_req <= 1'b0;
    repeat (2) @(negedge core_clk);
    check({remap_rvalid, remap_rdata}, {1'b1, exp_w[3][15:0]});
    @(posedge core_clk);
    fetch_pc   <= 24'h000005;
    fetch_load <= 1'b1;
    @(posedge core_clk);
    fetch_load <= 1'b0;
    fetch_req  <= 1'b1;
    repeat (2) @(posedge core_clk);
    fetch_req <= 1'b0;
    @(negedge core_clk);
    check({fetch_valid, fetch_word}, {1'b1, exp_w[2]});
    @(negedge core_clk);
    check({fetch_valid, fetch_word}, {1'b1, exp_w[3]});
    close_out();
  end
endmodule : test_program_space_table_access
`default_nettype wire
